// ==== hdl/serial_pkg.sv ====
// Purpose: shared constants and carrier types of the fast serial port
// Assumes: 50 MHz core clock, 8N1 framing, 16x oversampling
// Notes:   every count of cycles derives from the clock rate below
package serial_pkg;

    // ------------------------------------------------------------------
    // clock and bit timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
    localparam int BAUD_DEFAULT  = 115_200;
    localparam int OVERSAMPLE    = 16;
    // cycles per oversample tick; rounds down, never below one
    localparam int BAUD_DIV      = (CLK_HZ / (BAUD_DEFAULT * OVERSAMPLE)) < 1
                                   ? 1 : CLK_HZ / (BAUD_DEFAULT * OVERSAMPLE);
    localparam int DIV_W         = 16;

    localparam logic [3:0] MID_SAMPLE  = 4'h7;
    localparam logic [3:0] LAST_SAMPLE = 4'hf;

    // ------------------------------------------------------------------
    // character and buffer shape
    // ------------------------------------------------------------------
    localparam int         DATA_BITS  = 8;
    localparam logic [2:0] LAST_BIT   = 3'h7;
    localparam int         FIFO_DEPTH = 8;

    // ------------------------------------------------------------------
    // levels after reset
    // ------------------------------------------------------------------
    localparam logic LINE_IDLE    = 1'h1;
    localparam logic NEG_INACTIVE = 1'h1;

    // ------------------------------------------------------------------
    // state encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_START = 2'b01,
        TX_DATA  = 2'b10,
        TX_STOP  = 2'b11
    } tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } rx_state_t;

    // ------------------------------------------------------------------
    // pin carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic serial_rx_line;
        logic clear_to_send_n;
        logic carrier_detect_n;
        logic set_ready_n;
    } modem_in_t;

    typedef struct packed {
        logic serial_tx_line;
        logic request_to_send_n;
        logic terminal_ready_n;
    } modem_out_t;

    typedef struct packed {
        logic remote_ready;
        logic clear_to_send;
        logic carrier_detect;
    } modem_status_t;

    localparam modem_in_t MODEM_IN_RESET = '{
        serial_rx_line:   LINE_IDLE,
        clear_to_send_n:  NEG_INACTIVE,
        carrier_detect_n: NEG_INACTIVE,
        set_ready_n:      NEG_INACTIVE
    };

    localparam modem_out_t MODEM_OUT_RESET = '{
        serial_tx_line:    LINE_IDLE,
        request_to_send_n: NEG_INACTIVE,
        terminal_ready_n:  NEG_INACTIVE
    };

endpackage

// ==== hdl/serial_fifo.sv ====
// Purpose: small first-word-fall-through buffer for transmit bytes
// Assumes: DEPTH is a power of two
// Notes:   head word sits in an output register, so capacity is DEPTH+1
`timescale 1ns/1ps
module serial_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic                        head_valid;
        logic [WIDTH-1:0]            head;
    } fifo_state_t;

    fifo_state_t s_r;
    fifo_state_t s_nxt;
    logic        do_wr;
    logic        do_pop;
    logic        do_ld;

    assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = s_r.head_valid;
    assign out_data  = s_r.head;

    always_comb begin
        s_nxt  = s_r;
        do_wr  = ce && in_valid && in_ready;
        do_pop = ce && s_r.head_valid && out_ready;
        do_ld  = ce && (s_r.cnt != '0) && (!s_r.head_valid || do_pop);
        if (do_wr) begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp          = s_r.wp + 1'b1;
        end
        if (do_ld) begin
            s_nxt.head       = s_r.mem[s_r.rp];
            s_nxt.head_valid = 1'b1;
            s_nxt.rp         = s_r.rp + 1'b1;
        end else if (do_pop) begin
            s_nxt.head_valid = 1'b0;
        end
        s_nxt.cnt = s_r.cnt + (AW+1)'(do_wr) - (AW+1)'(do_ld);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

// ==== hdl/fast_serial_port.sv ====
// Purpose: fast serial port core with modem handshake and flow control
// Assumes: 8N1 frames, 16x oversample tick from divider or ext clock
// Notes:   modem pins pass through two-stage synchronisers
`timescale 1ns/1ps
module fast_serial_port #(
    parameter int DIV        = serial_pkg::BAUD_DIV,
    parameter int FIFO_DEPTH = serial_pkg::FIFO_DEPTH
) (
    // clock, reset, enable
    input  wire logic                              clk,
    input  wire logic                              rstn,
    input  wire logic                              ce,
    // control levels
    input  wire logic                              hw_flow_en,
    input  wire logic                              rts_level_sw,
    input  wire logic                              terminal_ready,
    input  wire logic                              ext_clk_sel,
    // transmit byte stream
    input  wire logic                              tx_valid,
    output logic                                   tx_ready,
    input  wire logic [serial_pkg::DATA_BITS-1:0]  tx_data,
    // receive byte stream
    output logic                                   rx_valid,
    output logic      [serial_pkg::DATA_BITS-1:0]  rx_data,
    output logic                                   rx_frame_err,
    output logic                                   rx_dropped,
    // status
    output serial_pkg::modem_status_t              status,
    output logic                                   tx_busy,
    // serial pins
    input  wire logic                              serial_ext_clock,
    input  wire serial_pkg::modem_in_t             modem_in,
    output serial_pkg::modem_out_t                 modem_out
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        serial_pkg::modem_in_t              meta;
        serial_pkg::modem_in_t              sync;
        logic                               ext_meta;
        logic                               ext_sync;
        logic                               ext_prev;
        logic [serial_pkg::DIV_W-1:0]       div_cnt;
        serial_pkg::tx_state_t              tx_state;
        logic [3:0]                         tx_os;
        logic [2:0]                         tx_bit;
        logic [serial_pkg::DATA_BITS-1:0]   tx_shift;
        serial_pkg::rx_state_t              rx_state;
        logic [3:0]                         rx_os;
        logic [2:0]                         rx_bit;
        logic [serial_pkg::DATA_BITS-1:0]   rx_shift;
        logic [serial_pkg::DATA_BITS-1:0]   rx_data;
        logic                               rx_valid;
        logic                               rx_frame_err;
        logic                               rx_dropped;
        serial_pkg::modem_out_t             pins;
    } core_state_t;

    localparam core_state_t CORE_RESET = '{
        meta:         serial_pkg::MODEM_IN_RESET,
        sync:         serial_pkg::MODEM_IN_RESET,
        ext_meta:     1'h0,
        ext_sync:     1'h0,
        ext_prev:     1'h0,
        div_cnt:      '0,
        tx_state:     serial_pkg::TX_IDLE,
        tx_os:        4'h0,
        tx_bit:       3'h0,
        tx_shift:     '0,
        rx_state:     serial_pkg::RX_IDLE,
        rx_os:        4'h0,
        rx_bit:       3'h0,
        rx_shift:     '0,
        rx_data:      '0,
        rx_valid:     1'h0,
        rx_frame_err: 1'h0,
        rx_dropped:   1'h0,
        pins:         serial_pkg::MODEM_OUT_RESET
    };

    localparam logic [serial_pkg::DIV_W-1:0] DIV_LAST =
        serial_pkg::DIV_W'(DIV - 1);

    core_state_t                       s_r;
    core_state_t                       s_nxt;
    logic                              q_valid;
    logic                              q_pop;
    logic [serial_pkg::DATA_BITS-1:0]  q_data;
    logic                              tick;
    logic                              cts_ok;
    logic                              dcd_ok;

    // true on the last oversample of a bit period
    function automatic logic bit_end(input logic [3:0] os);
        bit_end = (os == serial_pkg::LAST_SAMPLE);
    endfunction

    // ------------------------------------------------------------------
    // transmit buffer
    // ------------------------------------------------------------------
    serial_fifo #(
        .WIDTH (serial_pkg::DATA_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (q_valid),
        .out_ready (q_pop),
        .out_data  (q_data)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign modem_out             = s_r.pins;
    assign rx_valid              = s_r.rx_valid;
    assign rx_data               = s_r.rx_data;
    assign rx_frame_err          = s_r.rx_frame_err;
    assign rx_dropped            = s_r.rx_dropped;
    assign tx_busy               = (s_r.tx_state != serial_pkg::TX_IDLE);
    assign status.remote_ready   = !s_r.sync.set_ready_n;
    assign status.clear_to_send  = !s_r.sync.clear_to_send_n;
    assign status.carrier_detect = !s_r.sync.carrier_detect_n;

    // gates only read the second synchroniser stage
    assign cts_ok = !hw_flow_en || !s_r.sync.clear_to_send_n;
    assign dcd_ok = !hw_flow_en || !s_r.sync.carrier_detect_n;

    // pop happens only in idle, so clear-to-send is seen between characters
    assign q_pop = ce && (s_r.tx_state == serial_pkg::TX_IDLE)
                   && q_valid && cts_ok;

    // an external clock gives one tick per rising edge; it must run
    // well below half the core rate or edges are missed
    assign tick = ext_clk_sel ? (s_r.ext_sync && !s_r.ext_prev)
                              : (s_r.div_cnt == DIV_LAST);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        if (ce) begin
            s_nxt.meta     = modem_in;
            s_nxt.sync     = s_r.meta;
            s_nxt.ext_meta = serial_ext_clock;
            s_nxt.ext_sync = s_r.ext_meta;
            s_nxt.ext_prev = s_r.ext_sync;
            s_nxt.div_cnt  = (s_r.div_cnt == DIV_LAST) ? '0
                             : s_r.div_cnt + 1'b1;

            s_nxt.rx_valid     = 1'b0;
            s_nxt.rx_frame_err = 1'b0;
            s_nxt.rx_dropped   = 1'b0;

            // transmitter
            case (s_r.tx_state)
                serial_pkg::TX_IDLE: begin
                    if (q_pop) begin
                        s_nxt.tx_shift = q_data;
                        s_nxt.tx_os    = 4'h0;
                        s_nxt.tx_state = serial_pkg::TX_START;
                    end
                end
                serial_pkg::TX_START: begin
                    if (tick) begin
                        s_nxt.tx_os = s_r.tx_os + 1'b1;
                        if (bit_end(s_r.tx_os)) begin
                            s_nxt.tx_bit   = 3'h0;
                            s_nxt.tx_state = serial_pkg::TX_DATA;
                        end
                    end
                end
                serial_pkg::TX_DATA: begin
                    if (tick) begin
                        s_nxt.tx_os = s_r.tx_os + 1'b1;
                        if (bit_end(s_r.tx_os)) begin
                            s_nxt.tx_shift = s_r.tx_shift >> 1;
                            s_nxt.tx_bit   = s_r.tx_bit + 1'b1;
                            if (s_r.tx_bit == serial_pkg::LAST_BIT) begin
                                s_nxt.tx_state = serial_pkg::TX_STOP;
                            end
                        end
                    end
                end
                serial_pkg::TX_STOP: begin
                    if (tick) begin
                        s_nxt.tx_os = s_r.tx_os + 1'b1;
                        if (bit_end(s_r.tx_os)) begin
                            s_nxt.tx_state = serial_pkg::TX_IDLE;
                        end
                    end
                end
                default: begin
                    s_nxt.tx_state = serial_pkg::TX_IDLE;
                end
            endcase

            // line level follows the state being entered
            case (s_nxt.tx_state)
                serial_pkg::TX_START: s_nxt.pins.serial_tx_line = 1'b0;
                serial_pkg::TX_DATA:  s_nxt.pins.serial_tx_line =
                                          s_nxt.tx_shift[0];
                default:              s_nxt.pins.serial_tx_line =
                                          serial_pkg::LINE_IDLE;
            endcase

            // receiver
            case (s_r.rx_state)
                serial_pkg::RX_IDLE: begin
                    if (!s_r.sync.serial_rx_line) begin
                        s_nxt.rx_os    = 4'h0;
                        s_nxt.rx_state = serial_pkg::RX_START;
                    end
                end
                serial_pkg::RX_START: begin
                    if (tick) begin
                        s_nxt.rx_os = s_r.rx_os + 1'b1;
                        if (s_r.rx_os == serial_pkg::MID_SAMPLE) begin
                            // a glitch shorter than half a bit is ignored
                            if (s_r.sync.serial_rx_line) begin
                                s_nxt.rx_state = serial_pkg::RX_IDLE;
                            end else begin
                                s_nxt.rx_os    = 4'h0;
                                s_nxt.rx_bit   = 3'h0;
                                s_nxt.rx_state = serial_pkg::RX_DATA;
                            end
                        end
                    end
                end
                serial_pkg::RX_DATA: begin
                    if (tick) begin
                        s_nxt.rx_os = s_r.rx_os + 1'b1;
                        if (bit_end(s_r.rx_os)) begin
                            s_nxt.rx_shift = {s_r.sync.serial_rx_line,
                                s_r.rx_shift[serial_pkg::DATA_BITS-1:1]};
                            s_nxt.rx_bit   = s_r.rx_bit + 1'b1;
                            if (s_r.rx_bit == serial_pkg::LAST_BIT) begin
                                s_nxt.rx_state = serial_pkg::RX_STOP;
                            end
                        end
                    end
                end
                serial_pkg::RX_STOP: begin
                    if (tick) begin
                        s_nxt.rx_os = s_r.rx_os + 1'b1;
                        if (bit_end(s_r.rx_os)) begin
                            s_nxt.rx_state = serial_pkg::RX_IDLE;
                            if (!s_r.sync.serial_rx_line) begin
                                s_nxt.rx_frame_err = 1'b1;
                            end else if (dcd_ok) begin
                                s_nxt.rx_data  = s_r.rx_shift;
                                s_nxt.rx_valid = 1'b1;
                            end else begin
                                s_nxt.rx_dropped = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    s_nxt.rx_state = serial_pkg::RX_IDLE;
                end
            endcase

            // request to send: buffer occupancy or busy transmitter, else software level
            if (hw_flow_en) begin
                s_nxt.pins.request_to_send_n =
                    !(q_valid || s_nxt.tx_state != serial_pkg::TX_IDLE
                      || !tx_ready);
            end else begin
                s_nxt.pins.request_to_send_n = rts_level_sw;
            end

            s_nxt.pins.terminal_ready_n = !terminal_ready;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= CORE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

// ==== bench/serial_port_checker_assertions.sv ====
// Purpose: concurrent checks on the fast serial port pins
// Assumes: one clock, asynchronous active-low reset
// Notes:   modem pins reach the core two flops late
`timescale 1ns/1ps
module serial_port_checker #(
    parameter int DIV = 1
) (
    // clock and reset
    input wire logic                      clk,
    input wire logic                      rstn,
    // controls
    input wire logic                      ce,
    input wire logic                      hw_flow_en,
    input wire logic                      rts_level_sw,
    input wire logic                      terminal_ready,
    input wire logic                      ext_clk_sel,
    // stream status
    input wire logic                      tx_ready,
    input wire logic                      tx_busy,
    input wire logic                      rx_valid,
    input wire logic                      rx_dropped,
    input wire serial_pkg::modem_status_t status,
    // pins
    input wire serial_pkg::modem_in_t     modem_in,
    input wire serial_pkg::modem_out_t    modem_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ----------------------------------------------------------
    // low run on the transmit line, in clocks
    // ----------------------------------------------------------
    int low_run_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            low_run_r <= 0;
        else
            low_run_r <= modem_out.serial_tx_line ? 0 : low_run_r + 1;
    end

    a_dtr_follow: assert property (
        ce |=> modem_out.terminal_ready_n == !$past(terminal_ready))
        else $error("terminal ready pin wrong");
    a_rts_soft: assert property (
        ce && !hw_flow_en
        |=> modem_out.request_to_send_n == $past(rts_level_sw))
        else $error("request to send ignores software level");
    a_rts_pending: assert property (
        $past(ce) && $past(hw_flow_en) && (tx_busy || !$past(tx_ready))
        |-> !modem_out.request_to_send_n)
        else $error("request to send high while data waits");
    a_tx_fall_busy: assert property (
        $fell(modem_out.serial_tx_line) |-> tx_busy)
        else $error("transmit line fell while idle");
    a_tx_bit_len: assert property (
        $rose(modem_out.serial_tx_line) && !ext_clk_sel
        |-> low_run_r % (16 * DIV) == 0)
        else $error("transmit bit length wrong");
    a_cts_gate: assert property (
        $rose(tx_busy) && $past(hw_flow_en)
        |-> !$past(modem_in.clear_to_send_n, 3))
        else $error("character started without clear to send");
    a_rx_carrier: assert property (
        rx_valid && $past(hw_flow_en)
        |-> !$past(modem_in.carrier_detect_n, 3))
        else $error("byte kept without carrier");
    a_drop_reason: assert property (
        rx_dropped |-> $past(hw_flow_en) && !rx_valid)
        else $error("byte dropped without flow control");
    a_status_sync: assert property (
        $past(rstn, 2) && $past(ce) && $past(ce, 2)
        |-> status == ~{$past(modem_in.set_ready_n, 2),
            $past(modem_in.clear_to_send_n, 2),
            $past(modem_in.carrier_detect_n, 2)})
        else $error("modem status not two flops behind pins");
endmodule

bind fast_serial_port serial_port_checker #(.DIV(DIV)) u_chk (
    .clk, .rstn, .ce, .hw_flow_en, .rts_level_sw, .terminal_ready,
    .ext_clk_sel, .tx_ready, .tx_busy, .rx_valid, .rx_dropped, .status,
    .modem_in, .modem_out
);

// ==== bench/serial_modem_model.sv ====
// Purpose: behavioural remote modem facing the fast serial port
// Assumes: idle line high, 8N1 frames, bit_cyc clocks per bit
// Notes:   handshake lines move only when the bench asks
`timescale 1ns/1ps
module serial_modem_model (
    // clock
    input  wire logic             clk,
    // line from the port
    input  wire logic             tx_line,
    // lines toward the port
    output serial_pkg::modem_in_t pins,
    // decoded character, frame is {stop, data}
    output logic                  got,
    output logic [8:0]            frame
);
    int bit_cyc = 16;

    initial begin
        pins = serial_pkg::MODEM_IN_RESET;
        got = 1'b0;
        frame = 9'h000;
    end

    task automatic lines(input logic cts_n, input logic dcd_n,
                         input logic dsr_n);
        pins.clear_to_send_n = cts_n;
        pins.carrier_detect_n = dcd_n;
        pins.set_ready_n = dsr_n;
    endtask

    // a low stop bit provokes a framing fault on purpose
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] bits;
        bits = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            pins.serial_rx_line = bits[i];
            repeat (bit_cyc) @(posedge clk);
            #1;
        end
        pins.serial_rx_line = 1'b1;
    endtask

    // ----------------------------------------------------------
    // receiver: mid-bit sampling from the start edge
    // ----------------------------------------------------------
    always begin
        @(negedge tx_line);
        repeat (bit_cyc / 2) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            repeat (bit_cyc) @(posedge clk);
            frame[i] = tx_line;
        end
        #1 got = 1'b1;
        @(posedge clk);
        #1 got = 1'b0;
    end
endmodule

// ==== bench/fast_serial_port_tb.sv ====
// Purpose: self-checking bench for the fast serial port
// Assumes: DIV=1, so a bit is 16 clocks on the internal tick
// Notes:   a watcher matches each result with the oldest note
`timescale 1ns/1ps
module fast_serial_port_tb;
    logic clk = 0, rstn = 0, hw_flow_en = 0, rts_level_sw = 1, ce = 1;
    logic terminal_ready = 0, ext_clk_sel = 0, ext_clk = 0;
    logic tx_valid = 0, tx_ready, rx_valid, rx_frame_err, rx_dropped;
    logic tx_busy, m_got;
    logic [7:0] tx_data = 8'h00, rx_data;
    logic [8:0] m_frame;
    serial_pkg::modem_status_t status;
    wire serial_pkg::modem_in_t pins_in;
    serial_pkg::modem_out_t pins_out;
    logic [9:0] exp_rx[$];
    logic [8:0] exp_tx[$];
    int n_errors = 0, comparisons = 0, cycles = 0;

    fast_serial_port #(.DIV(1)) u_dut (
        .clk, .rstn, .ce, .hw_flow_en, .rts_level_sw,
        .terminal_ready, .ext_clk_sel, .tx_valid, .tx_ready, .tx_data,
        .rx_valid, .rx_data, .rx_frame_err, .rx_dropped, .status,
        .tx_busy, .serial_ext_clock(ext_clk), .modem_in(pins_in),
        .modem_out(pins_out)
    );
    serial_modem_model u_model (
        .clk, .tx_line(pins_out.serial_tx_line), .pins(pins_in),
        .got(m_got), .frame(m_frame)
    );

    always #10 clk = ~clk;
    always #40 ext_clk = ~ext_clk;

    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task automatic check(input logic [9:0] seen, input logic [9:0] want);
        comparisons++;
        if (seen !== want) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // valid rises only while there is room, so no request is withdrawn
    task automatic push(input logic [7:0] b, output logic took);
        took = tx_ready;
        tx_valid = took;
        tx_data = b;
        step(1);
        if (took) exp_tx.push_back({1'b1, b});
    endtask
    task automatic drain(input int limit);
        for (int i = 0; i < limit && exp_tx.size() + exp_rx.size(); i++)
            step(1);
        check(exp_tx.size() + exp_rx.size(), 0);
    endtask
    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            n_errors++;
            $display("Error at %0t: run hung", $time);
            results();
        end
    end
    always @(posedge clk) begin
        if (m_got)
            check(m_frame, exp_tx.size() ? exp_tx.pop_front() : 9'h0);
        if (rx_valid || rx_frame_err || rx_dropped)
            check(rx_valid ? {2'b00, rx_data} : {rx_frame_err, rx_dropped,
                  8'h00}, exp_rx.size() ? exp_rx.pop_front() : 10'h3ff);
    end

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        logic [7:0] b;
        logic took;
        int taken;
        void'($urandom(32'h29c3));
        step(10);
        check(pins_out, serial_pkg::MODEM_OUT_RESET);
        check({tx_ready, tx_busy, status}, 5'h10);
        rstn = 1;
        $display("test 1 done");
        terminal_ready = 1;
        u_model.lines(1, 1, 0);
        step(3);
        check({pins_out.terminal_ready_n, status}, 4'h4);
        u_model.lines(0, 0, 0);
        step(3);
        check(status, 3'h7);
        $display("test 2 done");
        repeat (4) begin
            b = 8'($urandom);
            rts_level_sw = b[0];
            step(2);
            check(pins_out.request_to_send_n, b[0]);
        end
        ce = 0;
        rts_level_sw = !rts_level_sw;
        step(3);
        check(pins_out.request_to_send_n, !rts_level_sw);
        ce = 1;
        $display("test 3 done");
        // remote stalls: buffer fills while nothing may start
        u_model.lines(1, 0, 0);
        hw_flow_en = 1;
        step(4);
        check(pins_out.request_to_send_n, 1'b1);
        taken = 0;
        repeat (12) begin
            push(8'($urandom), took);
            taken += took;
        end
        tx_valid = 0;
        step(30);
        check({taken[3:0], tx_ready, tx_busy,
               pins_out.request_to_send_n}, 7'h48);
        u_model.lines(0, 0, 0);
        drain(2500);
        step(20);
        check(pins_out.request_to_send_n, 1'b1);
        // clear to send drops mid character: it ends, the next waits
        push(8'h5a, took);
        tx_valid = 0;
        step(40);
        u_model.lines(1, 0, 0);
        push(8'ha5, took);
        tx_valid = 0;
        step(300);
        check({exp_tx.size() == 1, tx_busy}, 2'h2);
        u_model.lines(0, 0, 0);
        drain(400);
        $display("test 4 done");
        for (int k = 0; k < 4; k++) begin
            b = 8'($urandom);
            hw_flow_en = (k != 3);
            u_model.lines(0, k >= 2, 0);
            step(4);
            exp_rx.push_back(k == 1 ? 10'h200 :
                             k == 2 ? 10'h100 : {2'b00, b});
            u_model.send(b, k != 1);
            step(20);
        end
        drain(100);
        $display("test 5 done");
        ext_clk_sel = 1;
        u_model.bit_cyc = 64;
        push(8'($urandom), took);
        tx_valid = 0;
        drain(1500);
        step(40);
        $display("test 6 done");
        results();
    end
endmodule
